// ==== hw/bridge_pkg.sv ====
// Constants, types and state codes of the serial-to-SPI bridge.
// Assumes a 50 MHz core clock.
package bridge_pkg;
	localparam int CLK_KHZ = 50000;
	localparam int I2C_MAX_KHZ = 400;
	localparam int BUF_DEPTH = 200;
	localparam int FIFO_DEPTH = 16;
	localparam logic [7:0] CMD_CFG = 8'hF0;
	localparam logic [7:0] CMD_CLR_INT = 8'hF1;
	localparam logic [7:0] CMD_IDLE = 8'hF2;
	localparam int CFG_ORDER_BIT = 5;
	localparam int CFG_CPOL_BIT = 3;
	localparam int CFG_CPHA_BIT = 2;
	localparam int CFG_RATE_LSB = 0;
	localparam int SPI_KHZ_0 = 1843;
	localparam int SPI_KHZ_1 = 461;
	localparam int SPI_KHZ_2 = 115;
	localparam int SPI_KHZ_3 = 58;
	// Half periods round up so the rate never exceeds its figure
	localparam logic [8:0] HALF_0 = 9'((CLK_KHZ + 2 * SPI_KHZ_0 - 1) / (2 * SPI_KHZ_0));
	localparam logic [8:0] HALF_1 = 9'((CLK_KHZ + 2 * SPI_KHZ_1 - 1) / (2 * SPI_KHZ_1));
	localparam logic [8:0] HALF_2 = 9'((CLK_KHZ + 2 * SPI_KHZ_2 - 1) / (2 * SPI_KHZ_2));
	localparam logic [8:0] HALF_3 = 9'((CLK_KHZ + 2 * SPI_KHZ_3 - 1) / (2 * SPI_KHZ_3));
	typedef struct packed {
		logic lsb_first;
		logic cpol;
		logic cpha;
		logic [1:0] rate;
	} spi_cfg_t;
	localparam spi_cfg_t CFG_RESET = '0;
	typedef enum logic [4:0] {
		I_IDLE = 5'h01,
		I_RX = 5'h02,
		I_ACK = 5'h04,
		I_TX = 5'h08,
		I_RACK = 5'h10
	} i2c_st_t;
	typedef enum logic [3:0] {
		SP_IDLE = 4'h1,
		SP_SETUP = 4'h2,
		SP_SHIFT = 4'h4,
		SP_HOLD = 4'h8
	} spi_st_t;
endpackage

// ==== hw/serial_bridge.sv ====
// Serial slave to SPI master bridge with a 200-byte buffer and input FIFO.
// Assumes all pins are asynchronous to mclk_in; open-drain pins are resolved outside.
//
// Contract
// - Slave only, byte oriented, up to 400 kHz
// - Clock held low between bytes when stalled
// - First seven bits address, eighth is direction
// - Address is fixed upper plus three straps
// - Straps latched during reset only
// - No acknowledge while a function executes
// - 200-byte buffer; address, command, payload
// - Payload stored until STOP, then execute
// - Command 01h-0Fh starts transfer, bits pick selects
// - Any select combination accepted
// - Send exactly the received payload count
// - Returned byte overwrites its buffer slot
// - Four active-low slave select outputs
// - Interrupt output is open drain, low only
// - Device reset input is active low
// - SPI rate at most 1.8 Mbit/s
// - Read returns buffer, leaves it unchanged
// - Interrupt on transfer end, F1h clears
// - F0h loads order, mode and rate
// - F2h idles until own address seen
`timescale 1ns/100ps

module byte_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic in_valid_in,
	input wire logic [W-1:0] in_data_in,
	output logic in_ready_out,
	output logic out_valid_out,
	output logic [W-1:0] out_data_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_r [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	assign in_ready_out = cnt_r != (AW + 1)'(D);
	assign out_valid_out = cnt_r != '0;
	assign out_data_out = mem_r[rp_r];

	always_ff @(posedge mclk_in) begin
		if (push) begin
			mem_r[wp_r] <= in_data_in;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule

module serial_bridge
	import bridge_pkg::*;
#(
	parameter logic [3:0] ADDR_UPPER = 4'h5
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic reset_n_in,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic addr_strap_0_in,
	input wire logic addr_strap_1_in,
	input wire logic addr_strap_2_in,
	output logic spi_clk_out,
	output logic mosi_out,
	input wire logic miso_in,
	output logic slave_select_0_n_out,
	output logic slave_select_1_n_out,
	output logic slave_select_2_n_out,
	output logic slave_select_3_n_out,
	output logic int_n_out,
	output logic int_oe_out,
	output logic idle_out,
	output logic busy_out
);
	logic [1:0] scl_p, sda_p, miso_p, rstn_p;
	logic [2:0] strap_m, strap_s, addr_low_r;
	logic scl_d, sda_d;
	logic srst, scl_rise, scl_fall, start_c, stop_c;
	i2c_st_t ist_r;
	spi_st_t sst_r;
	logic [7:0] sh_r, cmd_r, cnt_r, rd_ptr_r, wr_ptr_r, push_data_r;
	logic [3:0] bcnt_r;
	logic first_r, addressed_r, rw_r, cmd_seen_r, sda_drv_r, scl_hold_r, ack_r;
	logic exec_pend_r, push_valid_r, wr_start_r, busy_r;
	logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [7:0] fifo_out_data;
	logic byte_end, match, addr_hit, exec_fire, busy;
	logic [7:0] buf_r [BUF_DEPTH];
	spi_cfg_t cfg_r;
	logic int_r, idle_r;
	logic [3:0] ss_n_r;
	logic sclk_r, mosi_r, spi_wr_r, spi_done_r;
	logic [7:0] tx_r, rx_r, rx_nxt, idx_r, len_r, spi_wdata_r;
	logic [8:0] half_r, half_lim;
	logic [3:0] edge_r;
	logic half_tick, sample, shift_out;

	// Two-stage synchronisers for every pin
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			scl_p <= 2'b11;
			sda_p <= 2'b11;
			miso_p <= 2'b00;
			rstn_p <= 2'b00;
			strap_m <= '0;
			strap_s <= '0;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_p <= {scl_p[0], scl_in};
			sda_p <= {sda_p[0], sda_in};
			miso_p <= {miso_p[0], miso_in};
			rstn_p <= {rstn_p[0], reset_n_in};
			strap_m <= {addr_strap_2_in, addr_strap_1_in, addr_strap_0_in};
			strap_s <= strap_m;
			scl_d <= scl_p[1];
			sda_d <= sda_p[1];
		end
	end

	assign srst = ~rstn_p[1];
	assign scl_rise = scl_p[1] & ~scl_d;
	assign scl_fall = ~scl_p[1] & scl_d;
	assign start_c = scl_p[1] & scl_d & sda_d & ~sda_p[1];
	assign stop_c = scl_p[1] & scl_d & ~sda_d & sda_p[1];

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			addr_low_r <= '0;
		end else if (srst) begin
			addr_low_r <= strap_s;
		end
	end

	assign busy = exec_pend_r | push_valid_r | fifo_out_valid | (sst_r != SP_IDLE);
	assign match = sh_r[7:1] == {ADDR_UPPER, addr_low_r};
	assign byte_end = (ist_r == I_RX) && (bcnt_r == 4'd8) && (scl_fall || scl_hold_r);
	assign addr_hit = byte_end && first_r && match && !busy;
	assign exec_fire = exec_pend_r && !push_valid_r && !fifo_out_valid && (sst_r == SP_IDLE);

	// Serial slave: never drives the clock except to stretch it
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ist_r <= I_IDLE;
			sh_r <= '0;
			bcnt_r <= '0;
			cmd_r <= '0;
			cnt_r <= '0;
			rd_ptr_r <= '0;
			push_data_r <= '0;
			{first_r, addressed_r, rw_r, cmd_seen_r, sda_drv_r} <= '0;
			{scl_hold_r, ack_r, exec_pend_r, push_valid_r, wr_start_r} <= '0;
		end else if (srst) begin
			ist_r <= I_IDLE;
			{first_r, addressed_r, cmd_seen_r, sda_drv_r} <= '0;
			{scl_hold_r, exec_pend_r, push_valid_r, wr_start_r} <= '0;
		end else begin
			wr_start_r <= 1'b0;
			if (push_valid_r && fifo_in_ready) begin
				push_valid_r <= 1'b0;
			end
			if (exec_fire) begin
				exec_pend_r <= 1'b0;
			end
			if (stop_c) begin
				ist_r <= I_IDLE;
				sda_drv_r <= 1'b0;
				scl_hold_r <= 1'b0;
				addressed_r <= 1'b0;
				if (addressed_r && !rw_r && cmd_seen_r) begin
					exec_pend_r <= 1'b1;
				end
			end else if (start_c) begin
				ist_r <= I_RX;
				bcnt_r <= '0;
				first_r <= 1'b1;
				addressed_r <= 1'b0;
				sda_drv_r <= 1'b0;
			end else begin
				unique case (ist_r)
				I_IDLE: begin
				end
				I_RX: begin
					if (scl_rise && bcnt_r != 4'd8) begin
						sh_r <= {sh_r[6:0], sda_p[1]};
						bcnt_r <= bcnt_r + 4'd1;
					end else if (byte_end) begin
						if (first_r) begin
							first_r <= 1'b0;
							if (addr_hit) begin
								addressed_r <= 1'b1;
								rw_r <= sh_r[0];
								cmd_seen_r <= 1'b0;
								cnt_r <= '0;
								rd_ptr_r <= '0;
								wr_start_r <= ~sh_r[0];
								sda_drv_r <= 1'b1;
								ist_r <= I_ACK;
							end else begin
								ist_r <= I_IDLE;
							end
						end else if (!cmd_seen_r) begin
							cmd_r <= sh_r;
							cmd_seen_r <= 1'b1;
							sda_drv_r <= 1'b1;
							ist_r <= I_ACK;
						end else if (cnt_r == 8'(BUF_DEPTH)) begin
							ist_r <= I_IDLE;
						end else if (push_valid_r) begin
							scl_hold_r <= 1'b1;
						end else begin
							scl_hold_r <= 1'b0;
							push_valid_r <= 1'b1;
							push_data_r <= sh_r;
							cnt_r <= cnt_r + 8'd1;
							sda_drv_r <= 1'b1;
							ist_r <= I_ACK;
						end
					end
				end
				I_ACK: begin
					if (scl_fall) begin
						bcnt_r <= '0;
						if (rw_r) begin
							sh_r <= buf_r[rd_ptr_r];
							sda_drv_r <= ~buf_r[rd_ptr_r][7];
							rd_ptr_r <= (rd_ptr_r == 8'(BUF_DEPTH - 1)) ? rd_ptr_r : rd_ptr_r + 8'd1;
							ist_r <= I_TX;
						end else begin
							sda_drv_r <= 1'b0;
							ist_r <= I_RX;
						end
					end
				end
				I_TX: begin
					if (scl_fall) begin
						bcnt_r <= bcnt_r + 4'd1;
						if (bcnt_r == 4'd7) begin
							sda_drv_r <= 1'b0;
							ist_r <= I_RACK;
						end else begin
							sh_r <= {sh_r[6:0], 1'b0};
							sda_drv_r <= ~sh_r[6];
						end
					end
				end
				I_RACK: begin
					if (scl_rise) begin
						ack_r <= ~sda_p[1];
					end else if (scl_fall) begin
						// Next byte starts on this fall, not one bit later
						bcnt_r <= '0;
						if (ack_r) begin
							sh_r <= buf_r[rd_ptr_r];
							sda_drv_r <= ~buf_r[rd_ptr_r][7];
							rd_ptr_r <= (rd_ptr_r == 8'(BUF_DEPTH - 1)) ? rd_ptr_r : rd_ptr_r + 8'd1;
							ist_r <= I_TX;
						end else begin
							ist_r <= I_IDLE;
						end
					end
				end
				endcase
			end
		end
	end

	byte_fifo #(
		.W(8),
		.D(FIFO_DEPTH)
	) u_fifo (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.in_valid_in(push_valid_r),
		.in_data_in(push_data_r),
		.in_ready_out(fifo_in_ready),
		.out_valid_out(fifo_out_valid),
		.out_data_out(fifo_out_data),
		.out_ready_in(fifo_out_ready)
	);

	// Drain stalls while a transfer owns the buffer
	assign fifo_out_ready = sst_r == SP_IDLE;

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr_r <= '0;
		end else if (wr_start_r) begin
			wr_ptr_r <= '0;
		end else if (fifo_out_valid && fifo_out_ready) begin
			wr_ptr_r <= wr_ptr_r + 8'd1;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (spi_wr_r) begin
			buf_r[idx_r] <= spi_wdata_r;
		end else if (fifo_out_valid && fifo_out_ready) begin
			buf_r[wr_ptr_r] <= fifo_out_data;
		end
	end

	// Command execution and status
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_r <= CFG_RESET;
			int_r <= 1'b0;
			idle_r <= 1'b0;
			busy_r <= 1'b0;
		end else if (srst) begin
			cfg_r <= CFG_RESET;
			int_r <= 1'b0;
			idle_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			busy_r <= busy;
			if (addr_hit) begin
				idle_r <= 1'b0;
			end
			if (exec_fire) begin
				if (cmd_r == CMD_CFG && cnt_r != '0) begin
					cfg_r.lsb_first <= buf_r[0][CFG_ORDER_BIT];
					cfg_r.cpol <= buf_r[0][CFG_CPOL_BIT];
					cfg_r.cpha <= buf_r[0][CFG_CPHA_BIT];
					cfg_r.rate <= buf_r[0][CFG_RATE_LSB +: 2];
				end
				if (cmd_r == CMD_CLR_INT) begin
					int_r <= 1'b0;
				end
				if (cmd_r == CMD_IDLE) begin
					idle_r <= 1'b1;
				end
			end
			if (spi_done_r) begin
				int_r <= 1'b1;
			end
		end
	end

	always_comb begin
		unique case (cfg_r.rate)
		2'd0: half_lim = HALF_0;
		2'd1: half_lim = HALF_1;
		2'd2: half_lim = HALF_2;
		2'd3: half_lim = HALF_3;
		endcase
	end

	assign half_tick = half_r == half_lim - 9'd1;
	assign sample = edge_r[0] == cfg_r.cpha;
	assign shift_out = edge_r[0] != cfg_r.cpha;
	assign rx_nxt = cfg_r.lsb_first ? {miso_p[1], rx_r[7:1]} : {rx_r[6:0], miso_p[1]};

	// SPI master engine
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			sst_r <= SP_IDLE;
			ss_n_r <= 4'hF;
			{sclk_r, mosi_r, spi_wr_r, spi_done_r} <= '0;
			{tx_r, rx_r, idx_r, len_r, spi_wdata_r} <= '0;
			half_r <= '0;
			edge_r <= '0;
		end else if (srst) begin
			sst_r <= SP_IDLE;
			ss_n_r <= 4'hF;
			{sclk_r, spi_wr_r, spi_done_r} <= '0;
		end else begin
			spi_wr_r <= 1'b0;
			spi_done_r <= 1'b0;
			if (spi_wr_r) begin
				idx_r <= idx_r + 8'd1;
			end
			half_r <= half_tick ? '0 : half_r + 9'd1;
			unique case (sst_r)
			SP_IDLE: begin
				sclk_r <= cfg_r.cpol;
				half_r <= '0;
				if (exec_fire && cmd_r[7:4] == 4'h0 && cmd_r[3:0] != 4'h0) begin
					if (cnt_r == '0) begin
						spi_done_r <= 1'b1;
					end else begin
						ss_n_r <= ~cmd_r[3:0];
						idx_r <= '0;
						len_r <= cnt_r;
						tx_r <= buf_r[0];
						sst_r <= SP_SETUP;
					end
				end
			end
			SP_SETUP: begin
				if (half_tick) begin
					edge_r <= '0;
					if (!cfg_r.cpha) begin
						mosi_r <= cfg_r.lsb_first ? tx_r[0] : tx_r[7];
						tx_r <= cfg_r.lsb_first ? tx_r >> 1 : tx_r << 1;
					end
					sst_r <= SP_SHIFT;
				end
			end
			SP_SHIFT: begin
				if (half_tick && !spi_wr_r) begin
					sclk_r <= ~sclk_r;
					edge_r <= edge_r + 4'd1;
					if (sample) begin
						rx_r <= rx_nxt;
					end
					if (shift_out && edge_r != 4'd15) begin
						mosi_r <= cfg_r.lsb_first ? tx_r[0] : tx_r[7];
						tx_r <= cfg_r.lsb_first ? tx_r >> 1 : tx_r << 1;
					end
					if (edge_r == 4'd15) begin
						spi_wr_r <= 1'b1;
						spi_wdata_r <= sample ? rx_nxt : rx_r;
						if (idx_r + 8'd1 == len_r) begin
							sst_r <= SP_HOLD;
						end else if (!cfg_r.cpha) begin
							mosi_r <= cfg_r.lsb_first ? buf_r[idx_r + 8'd1][0] : buf_r[idx_r + 8'd1][7];
							tx_r <= cfg_r.lsb_first ? buf_r[idx_r + 8'd1] >> 1 : buf_r[idx_r + 8'd1] << 1;
						end else begin
							tx_r <= buf_r[idx_r + 8'd1];
						end
					end
				end
			end
			SP_HOLD: begin
				if (half_tick) begin
					ss_n_r <= 4'hF;
					spi_done_r <= 1'b1;
					sst_r <= SP_IDLE;
				end
			end
			endcase
		end
	end

	assign scl_out = 1'b0;
	assign scl_oe_out = scl_hold_r;
	assign sda_out = 1'b0;
	assign sda_oe_out = sda_drv_r;
	assign int_n_out = 1'b0;
	assign int_oe_out = int_r;
	assign spi_clk_out = sclk_r;
	assign mosi_out = mosi_r;
	assign slave_select_0_n_out = ss_n_r[0];
	assign slave_select_1_n_out = ss_n_r[1];
	assign slave_select_2_n_out = ss_n_r[2];
	assign slave_select_3_n_out = ss_n_r[3];
	assign idle_out = idle_r;
	assign busy_out = busy_r;
endmodule

// ==== test/serial_bridge_sva.sv ====
// Checker for the bridge's pin-level timing.
// Assumes SCL and SDA inputs carry the resolved open-drain wire levels.
`timescale 1ns/100ps

module serial_bridge_sva (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe_out,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic spi_clk_out,
	input wire logic slave_select_0_n_out,
	input wire logic slave_select_1_n_out,
	input wire logic slave_select_2_n_out,
	input wire logic slave_select_3_n_out,
	input wire logic int_n_out,
	input wire logic int_oe_out,
	input wire logic busy_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	logic [3:0] ss_n;
	logic clk_q_r;
	logic [7:0] gap_r;
	assign ss_n = {slave_select_3_n_out, slave_select_2_n_out,
		slave_select_1_n_out, slave_select_0_n_out};
	// Cycles since the SPI clock last moved
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			clk_q_r <= 1'b0;
			gap_r <= 8'hFF;
		end else begin
			clk_q_r <= spi_clk_out;
			if (spi_clk_out != clk_q_r)
				gap_r <= 8'h00;
			else if (gap_r != 8'hFF)
				gap_r <= gap_r + 8'h01;
		end
	end
	sequence frame_end_s;
		$rose(&ss_n);
	endsequence
	sequence int_up_s;
		##[0:40] int_oe_out;
	endsequence
	od_pins_a: assert property (!scl_out && !sda_out && !int_n_out)
		else $error("open-drain pin drives high");
	ack_low_a: assert property ($rose(sda_oe_out) |-> !scl_in)
		else $error("SDA pulled while SCL high");
	stretch_low_a: assert property ($rose(scl_oe_out) |-> !scl_in)
		else $error("SCL hold started while SCL high");
	ss_busy_a: assert property (!(&ss_n) |-> ##1 busy_out)
		else $error("select active while not busy");
	// Idle level may follow a new polarity just after a command ends
	ss_frame_a: assert property ((spi_clk_out != clk_q_r) |->
		(!(&ss_n) && $stable(ss_n)) || $fell(busy_out))
		else $error("SPI clock edge outside a frame");
	clk_idle_a: assert property (&ss_n && $past(&ss_n) && !$fell(busy_out) |->
		$stable(spi_clk_out))
		else $error("SPI clock moves while idle");
	spi_rate_a: assert property ((spi_clk_out != clk_q_r) |-> gap_r >= 8'd13)
		else $error("SPI half period too short");
	int_done_a: assert property (frame_end_s |-> int_up_s)
		else $error("no interrupt after transfer");
endmodule

bind serial_bridge serial_bridge_sva chk_i (
	.mclk_in(mclk_in),
	.rst_in(rst_in),
	.scl_in(scl_in),
	.scl_out(scl_out),
	.scl_oe_out(scl_oe_out),
	.sda_out(sda_out),
	.sda_oe_out(sda_oe_out),
	.spi_clk_out(spi_clk_out),
	.slave_select_0_n_out(slave_select_0_n_out),
	.slave_select_1_n_out(slave_select_1_n_out),
	.slave_select_2_n_out(slave_select_2_n_out),
	.slave_select_3_n_out(slave_select_3_n_out),
	.int_n_out(int_n_out),
	.int_oe_out(int_oe_out),
	.busy_out(busy_out)
);

// ==== test/serial_bridge_tb.sv ====
// Self-checking bench: bit-banged two-wire master, SPI slave model.
// Assumes a pull-up on SCL, SDA and the interrupt line.
`timescale 1ns/100ps

module serial_bridge_tb;
	import bridge_pkg::*;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic reset_n_in = 1'b0;
	logic m_scl = 1'b1;
	logic m_sda = 1'b1;
	logic [2:0] strap = 3'b101;
	logic scl_oe, sda_oe, spi_clk, mosi, miso, busy, idle, int_oe;
	logic [3:0] ss_n;
	logic [15:0] got;
	logic [7:0] n_rx;
	logic scl_w, sda_w;
	int n_fail = 0;
	int n_checks = 0;
	assign scl_w = m_scl & !scl_oe;
	assign sda_w = m_sda & !sda_oe;
	initial forever #10 mclk_in = ~mclk_in;

	serial_bridge uut (
		.mclk_in(mclk_in), .rst_in(rst_in), .reset_n_in(reset_n_in),
		.scl_in(scl_w), .scl_out(), .scl_oe_out(scl_oe),
		.sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe),
		.addr_strap_0_in(strap[0]), .addr_strap_1_in(strap[1]),
		.addr_strap_2_in(strap[2]), .spi_clk_out(spi_clk), .mosi_out(mosi),
		.miso_in(miso), .slave_select_0_n_out(ss_n[0]),
		.slave_select_1_n_out(ss_n[1]), .slave_select_2_n_out(ss_n[2]),
		.slave_select_3_n_out(ss_n[3]), .int_n_out(), .int_oe_out(int_oe),
		.idle_out(idle), .busy_out(busy)
	);
	spi_slave_model partner (
		.mclk_in(mclk_in), .spi_clk_in(spi_clk), .mosi_in(mosi),
		.ss_n_in(ss_n[0]), .reply_in(8'hC3), .miso_out(miso),
		.got_out(got), .n_out(n_rx)
	);

	task tally_and_finish;
		$display("checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
			n_fail++;
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge mclk_in);
	endtask
	// Half the 160 ns link period is four core cycles
	task bit_io(input logic b, output logic r);
		int n;
		m_sda = b;
		cyc(4);
		m_scl = 1'b1;
		n = 0;
		while (scl_oe === 1'b1 && n < 2000) begin
			cyc(1);
			n++;
		end
		if (n >= 2000) begin
			n_fail++;
			tally_and_finish();
		end
		cyc(4);
		r = sda_w;
		m_scl = 1'b0;
	endtask
	task start_c;
		m_sda = 1'b1;
		cyc(4);
		m_scl = 1'b1;
		cyc(4);
		m_sda = 1'b0;
		cyc(4);
		m_scl = 1'b0;
	endtask
	task stop_c;
		m_sda = 1'b0;
		cyc(4);
		m_scl = 1'b1;
		cyc(4);
		m_sda = 1'b1;
		cyc(4);
	endtask
	task wr_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task rd_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask
	task wait_idle;
		int n;
		cyc(4);
		n = 0;
		while (busy !== 1'b0 && n < 20000) begin
			cyc(1);
			n++;
		end
		if (n >= 20000) begin
			n_fail++;
			tally_and_finish();
		end
	endtask
	task send_cmd(input logic [7:0] cmd);
		logic a;
		start_c();
		wr_byte(8'h5A, a);
		wr_byte(cmd, a);
		stop_c();
		wait_idle();
	endtask

	task t_reset;
		chk("selects", ss_n, 4'hF);
		chk("int", int_oe, 1'b0);
		chk("spi clock", spi_clk, 1'b0);
	endtask
	localparam logic [3:0] ADDR_UPPER_T = 4'h5;
	task t_addr;
		logic a;
		start_c();
		wr_byte({ADDR_UPPER_T, 3'b010, 1'b0}, a);
		chk("new strap ack", a, 1'b0);
		stop_c();
	endtask
	task t_spi;
		logic a;
		logic [7:0] d0, d1;
		start_c();
		wr_byte(8'h5A, a);
		chk("address ack", a, 1'b1);
		wr_byte(8'h05, a);
		wr_byte(8'hA5, a);
		wr_byte(8'h3C, a);
		chk("selects before stop", ss_n, 4'hF);
		stop_c();
		cyc(40);
		chk("selects in transfer", ss_n, 4'hA);
		start_c();
		wr_byte(8'h5A, a);
		chk("busy ack", a, 1'b0);
		stop_c();
		wait_idle();
		chk("spi byte count", n_rx, 8'h02);
		chk("spi bytes", got, 16'hA53C);
		chk("int after transfer", int_oe, 1'b1);
		for (int k = 0; k < 2; k++) begin
			start_c();
			wr_byte(8'h5B, a);
			rd_byte(1'b0, d0);
			rd_byte(1'b1, d1);
			stop_c();
			chk("returned bytes", {d0, d1}, 16'hC3C4);
		end
	endtask
	task t_clear;
		send_cmd(CMD_CLR_INT);
		chk("int cleared", int_oe, 1'b0);
	endtask
	task t_idle;
		logic a;
		send_cmd(CMD_IDLE);
		chk("idle entered", idle, 1'b1);
		start_c();
		wr_byte(8'h5A, a);
		stop_c();
		cyc(8);
		chk("idle left", idle, 1'b0);
	endtask
	// LSB first at the second rate, then one byte read back
	task t_cfg;
		logic a;
		logic [7:0] d0;
		int n;
		start_c();
		wr_byte(8'h5A, a);
		wr_byte(CMD_CFG, a);
		wr_byte(8'h21, a);
		stop_c();
		wait_idle();
		start_c();
		wr_byte(8'h5A, a);
		wr_byte(8'h01, a);
		wr_byte(8'h01, a);
		stop_c();
		n = 0;
		while (spi_clk !== 1'b1 && n < 2000) begin
			cyc(1);
			n++;
		end
		if (n >= 2000) begin
			n_fail++;
			tally_and_finish();
		end
		n = 0;
		while (spi_clk === 1'b1 && n < 2000) begin
			cyc(1);
			n++;
		end
		if (n >= 2000) begin
			n_fail++;
			tally_and_finish();
		end
		chk("half period", n, HALF_1);
		wait_idle();
		chk("lsb first byte", got[7:0], 8'h80);
		start_c();
		wr_byte(8'h5B, a);
		rd_byte(1'b1, d0);
		stop_c();
		chk("lsb first return", d0, 8'hA3);
	endtask

	initial begin
		cyc(4);
		rst_in = 1'b0;
		// Device reset pin outlasts the core reset so the straps get captured
		cyc(4);
		reset_n_in = 1'b1;
		cyc(2);
		strap = 3'b010;
		cyc(10);
		t_reset();
		t_addr();
		t_spi();
		t_clear();
		t_idle();
		t_cfg();
		tally_and_finish();
	end
endmodule

// ==== test/spi_slave_model.sv ====
// Behavioural SPI slave, mode 0, MSB first; replies reply_in plus byte index.
// Assumes the select it watches frames whole bytes.
`timescale 1ns/100ps

module spi_slave_model (
	input wire logic mclk_in,
	input wire logic spi_clk_in,
	input wire logic mosi_in,
	input wire logic ss_n_in,
	input wire logic [7:0] reply_in,
	output logic miso_out,
	output logic [15:0] got_out,
	output logic [7:0] n_out
);
	logic [7:0] sh;
	logic [7:0] rx;
	int bits;
	logic idle_r = 1'b0;
	initial begin
		got_out = 16'h0000;
		n_out = 8'h00;
	end
	// Deselected line shows a changing pattern, not the last bit
	always @(posedge mclk_in) idle_r <= ~idle_r;
	assign miso_out = ss_n_in ? idle_r : sh[7];
	always @(negedge ss_n_in) begin
		sh = reply_in + n_out;
		bits = 0;
	end
	always @(posedge spi_clk_in) if (!ss_n_in) begin
		rx = {rx[6:0], mosi_in};
		bits++;
		if (bits == 8) begin
			got_out = {got_out[7:0], rx};
			n_out++;
			bits = 0;
		end
	end
	always @(negedge spi_clk_in) if (!ss_n_in) begin
		sh = (bits == 0) ? reply_in + n_out : sh << 1;
	end
endmodule
